// File: btc_pkg.sv
package btc_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0]  BTC_OFF_EXT_TIMING  = 8'h00;
    localparam logic [7:0]  BTC_OFF_IDLE_CTRL   = 8'h04;
    localparam logic [7:0]  BTC_OFF_MEM_CTRL    = 8'h08;
    localparam logic [7:0]  BTC_OFF_DRAM_CTRL   = 8'h0c;
    localparam logic [7:0]  BTC_OFF_MEM_TYPE    = 8'h10;
    localparam logic [7:0]  BTC_OFF_STATUS      = 8'h14;

    // ==========================================================
    // Values after power-on reset and writable bit masks
    localparam logic [15:0] BTC_RST_EXT_TIMING  = 16'h0000;
    localparam logic [15:0] BTC_RST_IDLE_CTRL   = 16'h3ff3;
    localparam logic [15:0] BTC_RST_CTRL        = 16'h0000;
    localparam logic [15:0] BTC_RST_MEM_TYPE    = 16'h0000;
    localparam logic [15:0] BTC_MASK_EXT_TIMING = 16'hbf3f;
    localparam logic [15:0] BTC_MASK_IDLE_CTRL  = 16'hbff3;
    localparam logic [15:0] BTC_MASK_CTRL       = 16'h003f;
    localparam logic [15:0] BTC_MASK_MEM_TYPE   = 16'h0007;

    // ==========================================================
    // Field positions
    localparam int          BTC_EXTEND_BIT      = 15;
    localparam int          BTC_A3_RCD_LSB      = 10;
    localparam int          BTC_A3_TRAS_LSB     = 8;
    localparam int          BTC_A2_TPC_LSB      = 4;
    localparam int          BTC_A2_RCD_LSB      = 2;
    localparam int          BTC_A2_TRAS_LSB     = 0;
    localparam int          BTC_WAIT_SEL_BIT    = 15;
    localparam int          BTC_CTRL_TRAS_LSB   = 0;
    localparam int          BTC_CTRL_RCD_LSB    = 2;
    localparam int          BTC_CTRL_TPC_LSB    = 4;

    // ==========================================================
    // Memory type codes and bus responses
    localparam logic [2:0]  BTC_TYPE_A3_DRAM    = 3'h4;
    localparam logic [2:0]  BTC_TYPE_BOTH_DRAM  = 3'h5;
    localparam logic [1:0]  BTC_RESP_OKAY       = 2'h0;
    localparam logic [1:0]  BTC_RESP_SLVERR     = 2'h2;

    typedef enum logic [0:0] {
        BTC_ST_READY = 1'b0,
        BTC_ST_GAP   = 1'b1
    } btc_state_type;

    typedef struct packed {
        logic [2:0] a3_rcd;
        logic [2:0] a3_tras;
        logic [2:0] a2_rcd;
        logic [2:0] a2_tras;
        logic [3:0] a2_tpc;
        logic [3:0] a2_tpc_sr;
    } btc_timing_type;

    typedef struct packed {
        logic       valid;
        logic [2:0] area;
        logic       write;
    } btc_access_type;

    function automatic logic [2:0] btc_rcd_cycles(input logic [1:0] code);
        btc_rcd_cycles = {1'b0, code} + 3'h1;
    endfunction : btc_rcd_cycles

    function automatic logic [2:0] btc_tras_cycles(input logic [1:0] code);
        btc_tras_cycles = {1'b0, code} + 3'h2;
    endfunction : btc_tras_cycles

    function automatic logic [3:0] btc_tpc_sr_cycles(input logic [1:0] code);
        btc_tpc_sr_cycles = 4'h2 + {2'h0, code} + {1'b0, code, 1'b0};
    endfunction : btc_tpc_sr_cycles

    function automatic logic [1:0] btc_idle_cycles(input logic [15:0] idle_reg,
                                                  input logic [2:0]  area);
        logic [1:0] code;
        case (area)
            3'h0:    code = idle_reg[1:0];
            3'h2:    code = idle_reg[5:4];
            3'h3:    code = idle_reg[7:6];
            3'h4:    code = idle_reg[9:8];
            3'h5:    code = idle_reg[11:10];
            3'h6:    code = idle_reg[13:12];
            default: code = 2'h0;
        endcase
        btc_idle_cycles = (code == 2'h0) ? 2'h1 : code;
    endfunction : btc_idle_cycles

    function automatic logic [15:0] btc_merge(input logic [15:0] old_val,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  wstrb,
                                             input logic [15:0] mask);
        logic [15:0] lanes;
        lanes = {{8{wstrb[1]}}, {8{wstrb[0]}}};
        btc_merge = ((old_val & ~lanes) | (wdata[15:0] & lanes)) & mask;
    endfunction : btc_merge

    function automatic logic btc_mapped(input logic [7:0] addr);
        btc_mapped = (addr == BTC_OFF_EXT_TIMING) || (addr == BTC_OFF_IDLE_CTRL) ||
                     (addr == BTC_OFF_MEM_CTRL)   || (addr == BTC_OFF_DRAM_CTRL) ||
                     (addr == BTC_OFF_MEM_TYPE)   || (addr == BTC_OFF_STATUS);
    endfunction : btc_mapped

endpackage : btc_pkg

// File: btc_bus_timing_config.sv
`timescale 1ns/1ps
module btc_bus_timing_config (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_b,
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic [2:0]             s_axi_awprot,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic [2:0]             s_axi_arprot,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   bus_clock_output,
    input  wire logic                   wait_in,
    input  wire logic                   manual_reset,
    input  wire logic                   standby,
    input  wire btc_pkg::btc_access_type access_req,
    output logic                        access_ready,
    output btc_pkg::btc_access_type     access_start,
    output btc_pkg::btc_timing_type     timing,
    output logic                        extended_mode,
    output logic                        wait_sample_edge_select,
    output logic                        wait_sampled
);

    // ==========================================================
    // Register bus
    logic        aw_held, next_aw_held, w_held, next_w_held;
    logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [7:0]  waddr, next_waddr;
    logic [31:0] wdata, next_wdata, next_rdata;
    logic [3:0]  wstrb, next_wstrb;
    logic [1:0]  next_bresp, next_rresp;
    logic        write_fire;

    logic [15:0] ext_timing, next_ext_timing;
    logic [15:0] idle_ctrl, next_idle_ctrl;
    logic [15:0] mem_ctrl, next_mem_ctrl;
    logic [15:0] dram_ctrl, next_dram_ctrl;
    logic [15:0] mem_type, next_mem_type;
    logic [15:0] status_word;

    btc_pkg::btc_state_type state, next_state;
    logic [1:0]  gap_count, next_gap_count;

    assign write_fire = aw_held && w_held && !s_axi_bvalid;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_awready = s_axi_awready;
        next_wready  = s_axi_wready;
        next_waddr   = waddr;
        next_wdata   = wdata;
        next_wstrb   = wstrb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_arready = s_axi_arready;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_awready = 1'b0;
            next_waddr   = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_wready = 1'b0;
            next_wdata  = s_axi_wdata;
            next_wstrb  = s_axi_wstrb;
        end
        if (write_fire) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = btc_pkg::btc_mapped(waddr) ? btc_pkg::BTC_RESP_OKAY
                                                      : btc_pkg::BTC_RESP_SLVERR;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid  = 1'b0;
            next_awready = 1'b1;
            next_wready  = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rresp   = btc_pkg::btc_mapped(s_axi_araddr) ? btc_pkg::BTC_RESP_OKAY
                                                             : btc_pkg::BTC_RESP_SLVERR;
            case (s_axi_araddr)
                btc_pkg::BTC_OFF_EXT_TIMING: next_rdata = {16'h0000, ext_timing};
                btc_pkg::BTC_OFF_IDLE_CTRL:  next_rdata = {16'h0000, idle_ctrl};
                btc_pkg::BTC_OFF_MEM_CTRL:   next_rdata = {16'h0000, mem_ctrl};
                btc_pkg::BTC_OFF_DRAM_CTRL:  next_rdata = {16'h0000, dram_ctrl};
                btc_pkg::BTC_OFF_MEM_TYPE:   next_rdata = {16'h0000, mem_type};
                btc_pkg::BTC_OFF_STATUS:     next_rdata = {16'h0000, status_word};
                default:                     next_rdata = 32'h00000000;
            endcase
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            waddr         <= 8'h00;
            wdata         <= 32'h00000000;
            wstrb         <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'h0;
        end else begin
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            waddr         <= next_waddr;
            wdata         <= next_wdata;
            wstrb         <= next_wstrb;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    // ==========================================================
    // Configuration registers, loaded with their reset values only by power-on reset
    always_comb begin
        next_ext_timing = ext_timing;
        next_idle_ctrl  = idle_ctrl;
        next_mem_ctrl   = mem_ctrl;
        next_dram_ctrl  = dram_ctrl;
        next_mem_type   = mem_type;
        if (write_fire) begin
            case (waddr)
                btc_pkg::BTC_OFF_EXT_TIMING: next_ext_timing = btc_pkg::btc_merge(ext_timing,
                    wdata, wstrb, btc_pkg::BTC_MASK_EXT_TIMING);
                btc_pkg::BTC_OFF_IDLE_CTRL:  next_idle_ctrl = btc_pkg::btc_merge(idle_ctrl,
                    wdata, wstrb, btc_pkg::BTC_MASK_IDLE_CTRL);
                btc_pkg::BTC_OFF_MEM_CTRL:   next_mem_ctrl = btc_pkg::btc_merge(mem_ctrl,
                    wdata, wstrb, btc_pkg::BTC_MASK_CTRL);
                btc_pkg::BTC_OFF_DRAM_CTRL:  next_dram_ctrl = btc_pkg::btc_merge(dram_ctrl,
                    wdata, wstrb, btc_pkg::BTC_MASK_CTRL);
                btc_pkg::BTC_OFF_MEM_TYPE:   next_mem_type = btc_pkg::btc_merge(mem_type,
                    wdata, wstrb, btc_pkg::BTC_MASK_MEM_TYPE);
                default:                     next_mem_type = mem_type;
            endcase
        end
    end

    // Manual reset and standby do not touch these
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_timing <= btc_pkg::BTC_RST_EXT_TIMING;
            idle_ctrl  <= btc_pkg::BTC_RST_IDLE_CTRL;
            mem_ctrl   <= btc_pkg::BTC_RST_CTRL;
            dram_ctrl  <= btc_pkg::BTC_RST_CTRL;
            mem_type   <= btc_pkg::BTC_RST_MEM_TYPE;
        end else begin
            ext_timing <= next_ext_timing;
            idle_ctrl  <= next_idle_ctrl;
            mem_ctrl   <= next_mem_ctrl;
            dram_ctrl  <= next_dram_ctrl;
            mem_type   <= next_mem_type;
        end
    end

    // ==========================================================
    // Effective DRAM timing
    btc_pkg::btc_timing_type next_timing;
    logic        ext_on, a3_dram, a2_dram;
    logic [1:0]  a3_rcd_code, a3_tras_code, a2_rcd_code, a2_tras_code, a2_tpc_code;

    always_comb begin
        ext_on  = ext_timing[btc_pkg::BTC_EXTEND_BIT];
        a3_dram = (mem_type[2:0] == btc_pkg::BTC_TYPE_A3_DRAM) ||
                  (mem_type[2:0] == btc_pkg::BTC_TYPE_BOTH_DRAM);
        a2_dram = (mem_type[2:0] == btc_pkg::BTC_TYPE_BOTH_DRAM);
        a3_rcd_code  = (ext_on && a3_dram) ? ext_timing[btc_pkg::BTC_A3_RCD_LSB +: 2]
                                           : mem_ctrl[btc_pkg::BTC_CTRL_RCD_LSB +: 2];
        a3_tras_code = (ext_on && a3_dram) ? ext_timing[btc_pkg::BTC_A3_TRAS_LSB +: 2]
                                           : mem_ctrl[btc_pkg::BTC_CTRL_TRAS_LSB +: 2];
        a2_rcd_code  = ext_on ? ext_timing[btc_pkg::BTC_A2_RCD_LSB +: 2]
                              : dram_ctrl[btc_pkg::BTC_CTRL_RCD_LSB +: 2];
        a2_tras_code = ext_on ? ext_timing[btc_pkg::BTC_A2_TRAS_LSB +: 2]
                              : dram_ctrl[btc_pkg::BTC_CTRL_TRAS_LSB +: 2];
        a2_tpc_code  = (ext_on && a2_dram) ? ext_timing[btc_pkg::BTC_A2_TPC_LSB +: 2]
                                           : dram_ctrl[btc_pkg::BTC_CTRL_TPC_LSB +: 2];
        next_timing.a3_rcd    = btc_pkg::btc_rcd_cycles(a3_rcd_code);
        next_timing.a3_tras   = btc_pkg::btc_tras_cycles(a3_tras_code);
        next_timing.a2_rcd    = btc_pkg::btc_rcd_cycles(a2_rcd_code);
        next_timing.a2_tras   = btc_pkg::btc_tras_cycles(a2_tras_code);
        next_timing.a2_tpc    = {1'b0, btc_pkg::btc_rcd_cycles(a2_tpc_code)};
        next_timing.a2_tpc_sr = btc_pkg::btc_tpc_sr_cycles(a2_tpc_code);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            timing                  <= '0;
            extended_mode           <= 1'b0;
            wait_sample_edge_select <= 1'b0;
        end else begin
            timing                  <= next_timing;
            extended_mode           <= ext_on;
            wait_sample_edge_select <= idle_ctrl[btc_pkg::BTC_WAIT_SEL_BIT];
        end
    end

    // ==========================================================
    // Bus clock and wait input sampling
    logic [2:0]  bus_clock_output_sync, wait_sync;
    logic        bus_clock_output_level, next_bus_clock_output_level, wait_level, next_wait_level;
    logic        next_wait_sampled, bus_clock_output_rise, bus_clock_output_fall;

    always_comb begin
        next_bus_clock_output_level   = (bus_clock_output_sync[1] == bus_clock_output_sync[2]) ? bus_clock_output_sync[2] : bus_clock_output_level;
        next_wait_level   = (wait_sync[1] == wait_sync[2]) ? wait_sync[2] : wait_level;
        bus_clock_output_rise         = !bus_clock_output_level && next_bus_clock_output_level;
        bus_clock_output_fall         = bus_clock_output_level && !next_bus_clock_output_level;
        next_wait_sampled = wait_sampled;
        if (!idle_ctrl[btc_pkg::BTC_WAIT_SEL_BIT] && bus_clock_output_rise) begin
            next_wait_sampled = next_wait_level;
        end
        if (idle_ctrl[btc_pkg::BTC_WAIT_SEL_BIT] && bus_clock_output_fall) begin
            next_wait_sampled = next_wait_level;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_clock_output_sync    <= 3'h0;
            wait_sync    <= 3'h0;
            bus_clock_output_level   <= 1'b0;
            wait_level   <= 1'b0;
            wait_sampled <= 1'b0;
        end else begin
            bus_clock_output_sync    <= {bus_clock_output_sync[1:0], bus_clock_output};
            wait_sync    <= {wait_sync[1:0], wait_in};
            bus_clock_output_level   <= next_bus_clock_output_level;
            wait_level   <= next_wait_level;
            wait_sampled <= next_wait_sampled;
        end
    end

    // ==========================================================
    // Intercycle idle insertion, counted in bus clock cycles
    btc_pkg::btc_access_type pending, next_pending, last, next_last, next_start;
    logic        next_access_ready, need_gap;

    always_comb begin
        next_state        = state;
        next_gap_count    = gap_count;
        next_pending      = pending;
        next_last         = last;
        next_start        = '0;
        next_access_ready = 1'b0;
        need_gap          = last.valid && ((access_req.area != last.area) ||
                            (access_req.write && !last.write));
        case (state)
            btc_pkg::BTC_ST_READY: begin
                if (access_req.valid && access_ready) begin
                    next_last = access_req;
                    if (need_gap) begin
                        next_pending   = access_req;
                        next_gap_count = btc_pkg::btc_idle_cycles(idle_ctrl,
                                                                  last.area);
                        next_state     = btc_pkg::BTC_ST_GAP;
                    end else begin
                        next_start = access_req;
                    end
                end
            end
            btc_pkg::BTC_ST_GAP: begin
                if (bus_clock_output_rise) begin
                    next_gap_count = gap_count - 2'h1;
                    if (gap_count == 2'h1) begin
                        next_start = pending;
                        next_state = btc_pkg::BTC_ST_READY;
                    end
                end
            end
            default: next_state = btc_pkg::BTC_ST_READY;
        endcase
        if (manual_reset) begin
            next_state = btc_pkg::BTC_ST_READY;
            next_start = '0;
            next_last  = '0;
        end
        next_access_ready = (next_state == btc_pkg::BTC_ST_READY) && !standby &&
                            !manual_reset;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state        <= btc_pkg::BTC_ST_READY;
            gap_count    <= 2'h0;
            pending      <= '0;
            last         <= '0;
            access_start <= '0;
            access_ready <= 1'b0;
        end else begin
            state        <= next_state;
            gap_count    <= next_gap_count;
            pending      <= next_pending;
            last         <= next_last;
            access_start <= next_start;
            access_ready <= next_access_ready;
        end
    end

    assign status_word = {10'h000, wait_level, bus_clock_output_level, wait_sampled,
                          (state == btc_pkg::BTC_ST_GAP), gap_count};

endmodule : btc_bus_timing_config

// File: btc_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// Port-level checks of the timing configuration block
module btc_assertions (
    input wire logic                    ref_clk,
    input wire logic                    rst_b,
    input wire logic                    s_axi_bvalid,
    input wire logic [31:0]             s_axi_rdata,
    input wire logic                    s_axi_rvalid,
    input wire logic                    wait_in,
    input wire logic                    manual_reset,
    input wire btc_pkg::btc_access_type access_req,
    input wire logic                    access_ready,
    input wire btc_pkg::btc_access_type access_start,
    input wire btc_pkg::btc_timing_type timing,
    input wire logic                    extended_mode,
    input wire logic                    wait_sampled
);
    logic [4:0] wc;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Cycles since the wait pin last moved
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) wc <= 5'h00;
        else if ($changed(wait_in)) wc <= 5'h00;
        else if (wc != 5'h1f) wc <= wc + 5'h01;
    end
    ext_rsv_a: assert property (s_axi_rvalid |-> s_axi_rdata[14] == 1'b0)
        else $error("reserved bit reads one");
    rcd_rng_a: assert property (timing.a3_rcd != 3'h0 |-> timing.a3_rcd <= 3'h4
        && timing.a2_rcd inside {[3'h1:3'h4]}) else $error("delay out of range");
    tras_rng_a: assert property (timing.a3_tras != 3'h0 |-> timing.a3_tras inside {[3'h2:3'h5]}
        && timing.a2_tras inside {[3'h2:3'h5]}) else $error("assert time out of range");
    tpc_sr_a: assert property (timing.a2_tpc != 4'h0 |-> timing.a2_tpc_sr ==
        {timing.a2_tpc[2:0], 1'b0} + timing.a2_tpc - 4'h1) else $error("precharge mismatch");
    tim_follow_a: assert property ($changed(timing) && $past(rst_b, 2) |-> $past(s_axi_bvalid))
        else $error("timing moved without a write");
    start_bound_a: assert property (access_req.valid && access_ready |-> ##[1:40] access_start.valid)
        else $error("access never started");
    wait_hold_a: assert property (wc == 5'h14 |-> wait_sampled == wait_in)
        else $error("wait level not captured");
    keep_regs_a: assert property (manual_reset |=> $stable(extended_mode))
        else $error("manual reset changed a register");
endmodule : btc_assertions
bind btc_bus_timing_config btc_assertions chk_i (.*);

// File: btc_mem_model.sv
`timescale 1ns/1ps
module btc_mem_model (
    output logic     bus_clock_output,
    output logic     wait_in,
    input wire logic async_wait,
    input wire logic wait_level
);
    initial begin
        bus_clock_output = 1'b0;
        wait_in = 1'b0;
        #7;
        forever #80 bus_clock_output = ~bus_clock_output;
    end
    always @(posedge bus_clock_output) if (!async_wait) wait_in <= wait_level;
    always @(wait_level) if (async_wait) wait_in <= #13 wait_level;
endmodule : btc_mem_model

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'b0, rst_b = 1'b0, manual_reset = 1'b0, standby = 1'b0, aw = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, wl = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, dn;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, sd = 32'hbcf9d780;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic bus_clock_output, wait_in, access_ready, extended_mode;
    logic wait_sample_edge_select, wait_sampled;
    btc_pkg::btc_access_type access_req = 5'h00, access_start;
    btc_pkg::btc_timing_type timing;
    int bad_count = 0, n_checks = 0, ext = 0, idl = 16'h3ff3, dc = 0, mc = 0, mt = 0, n, g;
    always #10 ref_clk = ~ref_clk;
    btc_bus_timing_config dut (.s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'h3), .*);
    btc_mem_model mem (.async_wait(aw), .wait_level(wl), .*);
    function automatic logic [31:0] nx(input logic [31:0] s);
        nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    // Expected decoded timing from the register model
    function automatic int tx();
        int s3, s2, sp;
        s3 = ext[15] && mt[2] ? ext >> 8 : mc;
        s2 = ext[15] ? ext : dc;
        sp = ext[15] && mt == 5 ? ext : dc;
        tx = ((s3 >> 2 & 3) + 1) << 17 | ((s3 & 3) + 2) << 14 | ((s2 >> 2 & 3) + 1) << 11
             | ((s2 & 3) + 2) << 8 | ((sp >> 4 & 3) + 1) << 4 | (sp >> 4 & 3) * 3 + 2;
    endfunction : tx
    task automatic chk(input logic [31:0] gv, input logic [31:0] ev);
        n_checks++;
        if (gv !== ev) begin
            bad_count++;
            $display("BAD at %0t: got %h expected %h", $time, gv, ev);
        end
    endtask : chk
    task automatic xfer(input bit w, input logic [7:0] a, input int v, input logic [1:0] er = 2'h0);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= 32'(v);
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        dn = 1'b0;
        while (!dn) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            dn = w ? s_axi_bvalid : s_axi_rvalid;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (!w) chk(s_axi_rdata, 32'(v));
        chk(32'(w ? s_axi_bresp : s_axi_rresp), 32'(er));
    endtask : xfer
    task automatic acc(input int a, input bit w);
        @(posedge ref_clk);
        while (!access_ready) @(posedge ref_clk);
        access_req <= {1'b1, 3'(a), w};
        @(posedge ref_clk);
        access_req <= 5'h00;
        n = 0;
        while (n < 99 && access_start.valid !== 1'b1) begin
            @(posedge ref_clk);
            n++;
        end
        chk(32'(access_start), 32'({1'b1, 3'(a), w}));
    endtask : acc
    task automatic results();
        $display("Checks: %0d, mismatches: %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    initial begin
        repeat (30000) @(posedge ref_clk);
        bad_count++;
        results();
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        xfer(0, 8'h04, idl);
        chk(32'(timing), tx());
        for (int k = 0; k < 6; k++) begin
            sd = nx(sd);
            ext = {k[0], sd[14:0]} & 16'hbf3f;
            mt = 5 - k[1];
            xfer(1, 8'h00, ext);
            xfer(1, 8'h0c, sd[31:16]);
            xfer(1, 8'h08, sd[28:13]);
            xfer(1, 8'h10, mt);
            dc = sd[21:16];
            mc = sd[18:13];
            xfer(0, 8'h00, ext);
            chk(32'(timing), tx());
            chk(32'(extended_mode), ext >> 15);
        end
        xfer(1, 8'h18, 1, 2'h2);
        xfer(0, 8'h18, 0, 2'h2);
        for (int k = 0; k < 5; k++) begin
            sd = nx(sd);
            idl = sd[15:0] & 16'h3ff3;
            g = (idl >> 4 & 3) < 2 ? 1 : idl >> 4 & 3;
            xfer(1, 8'h04, idl);
            acc(2, 0);
            acc(2, 0);
            chk(n, 1);
            acc(2, 1);
            chk(32'(n >= g * 8 - 6 && n <= g * 8 + 1), 1);
            acc(k == 0 ? 0 : k + 2, 1);
            chk(32'(n >= g * 8 - 6 && n <= g * 8 + 1), 1);
            acc(k == 0 ? 0 : k + 2, 0);
            chk(n, 1);
        end
        for (int k = 0; k < 4; k++) begin
            aw <= k[1];
            xfer(1, 8'h04, {k[1], 15'h3ff3});
            wl <= !k[0];
            repeat (40) @(posedge ref_clk);
            chk(32'(wait_sampled), 32'(!k[0]));
            chk(32'(wait_sample_edge_select), 32'(k[1]));
        end
        manual_reset <= 1'b1;
        repeat (3) @(posedge ref_clk);
        manual_reset <= 1'b0;
        standby <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(32'(access_ready), 0);
        standby <= 1'b0;
        xfer(0, 8'h04, 16'hbff3);
        xfer(0, 8'h00, ext);
        xfer(1, 8'h00, 16'h8101);
        xfer(1, 8'h0c, 1);
        xfer(1, 8'h08, 1);
        ext = 16'h8101;
        dc = 1;
        mc = 1;
        repeat (2) @(posedge ref_clk);
        chk(32'(timing), tx());
        rst_b <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        xfer(0, 8'h04, 16'h3ff3);
        xfer(0, 8'h00, 0);
        results();
    end
endmodule : tb_top
